// [rtl/hblcs_defs.svh]
/*
  shared constants for the host-side flash bus controller: register offsets,
  field positions, reset values and strobe timing counts.
  assumes a 100 MHz controller clock; included by bare name.
*/
`ifndef HBLCS_DEFS_SVH
`define HBLCS_DEFS_SVH

// controller register offsets (word index on the software port)
`define HBLCS_REG_CTRL      4'h0
`define HBLCS_REG_ADDR      4'h1
`define HBLCS_REG_WDATA     4'h2
`define HBLCS_REG_RDATA     4'h3
`define HBLCS_REG_STATUS    4'h4
`define HBLCS_REG_CMD       4'h5
`define HBLCS_REG_DEVSEL    4'h6

// ctrl field positions
`define HBLCS_CTRL_WIDE     0
`define HBLCS_CTRL_SIZE_LO  1
`define HBLCS_CTRL_SIZE_HI  2
`define HBLCS_CTRL_RESET    8'h00

// status field positions
`define HBLCS_ST_BUSY       0
`define HBLCS_ST_READY      1
`define HBLCS_ST_DONE       2
`define HBLCS_ST_REFUSED    3

// cmd codes
`define HBLCS_CMD_READ      2'h1
`define HBLCS_CMD_WRITE     2'h2

// device-side address of the device-select register (arbitrary default)
`define HBLCS_DEVSEL_ADDR   13'h1000

// strobe timing, ns and derived cycles at 10 ns
`define HBLCS_CLK_NS        10
`define HBLCS_TSU_A_NS      10
`define HBLCS_TACC_NS       103
`define HBLCS_THIZ_NS       25
`define HBLCS_TREC_NS       20
`define HBLCS_TSU_A_CYC     ((`HBLCS_TSU_A_NS + `HBLCS_CLK_NS - 1) / `HBLCS_CLK_NS)
`define HBLCS_TACC_CYC      ((`HBLCS_TACC_NS + `HBLCS_CLK_NS - 1) / `HBLCS_CLK_NS)
`define HBLCS_THIZ_CYC      ((`HBLCS_THIZ_NS + `HBLCS_CLK_NS - 1) / `HBLCS_CLK_NS)
`define HBLCS_TREC_CYC      ((`HBLCS_TREC_NS + `HBLCS_CLK_NS - 1) / `HBLCS_CLK_NS)

`endif

// [rtl/hblcs_pkg.sv]
/*
  types for the host-side flash bus controller.
  assumes nothing beyond a SystemVerilog compiler.
*/
package hblcs_pkg;

  typedef enum logic [1:0] {
    HBLCS_SZ_WORD = 2'h0,
    HBLCS_SZ_EVEN = 2'h1,
    HBLCS_SZ_ODD  = 2'h2,
    HBLCS_SZ_NOP  = 2'h3
  } hblcs_size_e;

  typedef enum logic [5:0] {
    HBLCS_ST_IDLE   = 6'b000001,
    HBLCS_ST_SETUP  = 6'b000010,
    HBLCS_ST_STROBE = 6'b000100,
    HBLCS_ST_HOLD   = 6'b001000,
    HBLCS_ST_RECOV  = 6'b010000,
    HBLCS_ST_SEL    = 6'b100000
  } hblcs_state_e;

  typedef logic [15:0] hblcs_data_t;

endpackage : hblcs_pkg

// [rtl/hblcs_lane.sv]
/*
  byte-lane steering for one transfer: picks A0 and the high-byte enable
  from width and size, and packs or unpacks the two lanes.
  assumes the caller holds inputs steady for the whole cycle.
*/
`timescale 1ns/100ps
module hblcs_lane
  import hblcs_pkg::*;
(
  input  wire logic                  wide_i,
  input  wire hblcs_pkg::hblcs_size_e size_i,
  input  wire logic                  addr0_i,
  input  wire hblcs_pkg::hblcs_data_t wdata_i,
  input  wire hblcs_pkg::hblcs_data_t pin_d_i,
  output logic                       a0_o,
  output logic                       high_byte_enable_n_o,
  output logic                       lo_en_o,
  output logic                       hi_en_o,
  output hblcs_pkg::hblcs_data_t     pin_d_o,
  output hblcs_pkg::hblcs_data_t     rdata_o
);
  always_comb begin
    a0_o                 = addr0_i;
    high_byte_enable_n_o = 1'b1;
    lo_en_o              = 1'b1;
    hi_en_o              = 1'b0;
    pin_d_o              = {8'h00, wdata_i[7:0]};
    rdata_o              = {8'h00, pin_d_i[7:0]};
    if (!wide_i) begin
      // byte mode: upper lane left to the device pull-ups
      lo_en_o = 1'b1;
    end else begin
      unique case (size_i)
        HBLCS_SZ_WORD: begin
          a0_o = 1'b0;
          high_byte_enable_n_o = 1'b0;
          hi_en_o = 1'b1;
          pin_d_o = wdata_i;
          rdata_o = pin_d_i;
        end
        HBLCS_SZ_ODD: begin
          a0_o = 1'b1;
          high_byte_enable_n_o = 1'b0;
          lo_en_o = 1'b0;
          hi_en_o = 1'b1;
          pin_d_o = {wdata_i[7:0], 8'h00};
          rdata_o = {8'h00, pin_d_i[15:8]};
        end
        HBLCS_SZ_EVEN: begin
          a0_o = 1'b0;
        end
        HBLCS_SZ_NOP: begin
          a0_o = 1'b1;
          lo_en_o = 1'b0;
          rdata_o = 16'h0000;
        end
      endcase
    end
  end
endmodule : hblcs_lane

// [rtl/hblcs_host.sv]
/*
  host-side controller for an SRAM-like flash bus port: runs chip-enable,
  output-enable and write-enable cycles, steers byte lanes, waits on the
  init-pending pin and selects a cascaded device before talking to it.
  assumes software on a plain register port, one clock at 100 MHz, and a
  device whose pins are synchronous to that clock.
*/
// Local design decisions: the strobed register port and the register addresses.
// Overview of operation
// - bit 0 and bit 8 are lane lsbs
// - host waits for init-pending release before access
// - byte mode uses only the low lane
// - enable low, a0 low: full word
// - word-only host may tie both low
// - long-word host maps device a1 to bit2
// - long-word host ties device a0 low
// - at most four single-die devices cascaded
// - straps give position; single device is zero
// - write position to device-select register first (the code does this only when devsel differs from the position last selected)
`timescale 1ns/100ps
`include "hblcs_defs.svh"
module hblcs_host
  import hblcs_pkg::*;
(
  input  wire logic                   MCLK_I,
  input  wire logic                   RESET_N_I,
  input  wire logic [3:0]             REG_ADDR_I,
  input  wire logic [31:0]            REG_WDATA_I,
  input  wire logic                   REG_WR_I,
  input  wire logic                   REG_RD_I,
  output logic      [31:0]            REG_RDATA_O,
  output logic      [12:0]            DEV_ADDR_O,
  output logic                        CHIP_ENABLE_N_O,
  output logic                        OUTPUT_ENABLE_N_O,
  output logic                        WRITE_ENABLE_N_O,
  output logic                        HIGH_BYTE_ENABLE_N_O,
  output logic                        WIDTH_SELECT_O,
  input  wire hblcs_pkg::hblcs_data_t DEV_DATA_I,
  output hblcs_pkg::hblcs_data_t      DEV_DATA_O,
  output logic      [1:0]             DEV_DATA_OE_O,
  input  wire logic                   INIT_PENDING_N_I
);
  import hblcs_pkg::*;

  hblcs_state_e state_ff, nxt_state;
  logic [7:0]   ctrl_ff;
  logic [12:0]  addr_ff;
  hblcs_data_t  wdata_ff;
  hblcs_data_t  rdata_ff;
  logic [1:0]   devsel_ff;
  logic [1:0]   cmd_ff;
  logic         done_ff;
  logic         refused_ff;
  logic         sel_pend_ff;
  logic [3:0]   cnt_ff;
  logic [1:0]   cur_pos_ff;
  logic         wr_ff;
  logic         oe_ff;
  logic         ce_ff;
  logic         init_ff;

  logic         lane_a0;
  logic         lane_hbe_n;
  logic         lane_lo;
  logic         lane_hi;
  hblcs_data_t  lane_dout;
  hblcs_data_t  lane_rdata;
  logic         start;
  logic         busy;
  logic [12:0]  cyc_addr;
  hblcs_data_t  cyc_wdata;
  hblcs_size_e  cyc_size;

  function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] r);
    reg_hit = (a == r);
  endfunction : reg_hit

  // device select cycle is always an even-byte transfer on the low lane
  assign cyc_addr  = sel_pend_ff ? `HBLCS_DEVSEL_ADDR : addr_ff;
  assign cyc_wdata = sel_pend_ff ? {14'h0000, devsel_ff} : wdata_ff;
  assign cyc_size  = sel_pend_ff ? HBLCS_SZ_EVEN
                                 : hblcs_size_e'(ctrl_ff[`HBLCS_CTRL_SIZE_HI:`HBLCS_CTRL_SIZE_LO]);

  hblcs_lane u_lane (
    .wide_i               (ctrl_ff[`HBLCS_CTRL_WIDE]),
    .size_i               (cyc_size),
    .addr0_i              (cyc_addr[0]),
    .wdata_i              (cyc_wdata),
    .pin_d_i              (DEV_DATA_I),
    .a0_o                 (lane_a0),
    .high_byte_enable_n_o (lane_hbe_n),
    .lo_en_o              (lane_lo),
    .hi_en_o              (lane_hi),
    .pin_d_o              (lane_dout),
    .rdata_o              (lane_rdata)
  );

  // init-pending is the only readiness gate; never reused for array activity
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      init_ff <= 1'b1;
    end else begin
      init_ff <= !INIT_PENDING_N_I;
    end
  end

  assign busy  = !state_ff[0];
  assign start = REG_WR_I && reg_hit(REG_ADDR_I, `HBLCS_REG_CMD) && !busy && !init_ff;

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      ctrl_ff   <= `HBLCS_CTRL_RESET;
      addr_ff   <= 13'h0000;
      wdata_ff  <= 16'h0000;
      devsel_ff <= 2'h0;
    end else if (REG_WR_I && !busy) begin
      if (reg_hit(REG_ADDR_I, `HBLCS_REG_CTRL)) begin
        ctrl_ff <= REG_WDATA_I[7:0];
      end
      if (reg_hit(REG_ADDR_I, `HBLCS_REG_ADDR)) begin
        addr_ff <= REG_WDATA_I[12:0];
      end
      if (reg_hit(REG_ADDR_I, `HBLCS_REG_WDATA)) begin
        wdata_ff <= REG_WDATA_I[15:0];
      end
      if (reg_hit(REG_ADDR_I, `HBLCS_REG_DEVSEL)) begin
        devsel_ff <= REG_WDATA_I[1:0];
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      cmd_ff <= 2'h0;
    end else if (start) begin
      cmd_ff <= REG_WDATA_I[1:0];
    end
  end

  // select cycle precedes any access whose target position changed
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      sel_pend_ff <= 1'b0;
      cur_pos_ff  <= 2'h0;
    end else if (start) begin
      sel_pend_ff <= (devsel_ff != cur_pos_ff);
    end else if (state_ff == HBLCS_ST_SEL) begin
      sel_pend_ff <= 1'b0;
      cur_pos_ff  <= devsel_ff;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      HBLCS_ST_IDLE:   if (start) nxt_state = HBLCS_ST_SETUP;
      HBLCS_ST_SETUP:  if (cnt_ff == 4'h0) nxt_state = HBLCS_ST_STROBE;
      HBLCS_ST_STROBE: if (cnt_ff == 4'h0) nxt_state = HBLCS_ST_HOLD;
      HBLCS_ST_HOLD:   if (cnt_ff == 4'h0) nxt_state = HBLCS_ST_RECOV;
      HBLCS_ST_RECOV:  if (cnt_ff == 4'h0) nxt_state = sel_pend_ff ? HBLCS_ST_SEL
                                                                   : HBLCS_ST_IDLE;
      HBLCS_ST_SEL:    nxt_state = HBLCS_ST_SETUP;
      default:         nxt_state = HBLCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      state_ff <= HBLCS_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // every phase timed in clocks; the device itself only sees strobe edges
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      cnt_ff <= 4'h0;
    end else if (nxt_state != state_ff) begin
      unique case (nxt_state)
        HBLCS_ST_SETUP:  cnt_ff <= 4'(`HBLCS_TSU_A_CYC - 1);
        HBLCS_ST_STROBE: cnt_ff <= 4'(`HBLCS_TACC_CYC - 1);
        HBLCS_ST_HOLD:   cnt_ff <= 4'(`HBLCS_THIZ_CYC - 1);
        HBLCS_ST_RECOV:  cnt_ff <= 4'(`HBLCS_TREC_CYC - 1);
        default:         cnt_ff <= 4'h0;
      endcase
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end

  // the select cycle is a write whatever the pending command is
  always_comb begin
    wr_ff = sel_pend_ff || (cmd_ff == `HBLCS_CMD_WRITE);
    oe_ff = !wr_ff && state_ff == HBLCS_ST_STROBE;
    ce_ff = state_ff == HBLCS_ST_SETUP || state_ff == HBLCS_ST_STROBE
            || state_ff == HBLCS_ST_HOLD;
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      DEV_ADDR_O           <= 13'h0000;
      CHIP_ENABLE_N_O      <= 1'b1;
      OUTPUT_ENABLE_N_O    <= 1'b1;
      WRITE_ENABLE_N_O     <= 1'b1;
      HIGH_BYTE_ENABLE_N_O <= 1'b1;
      DEV_DATA_O           <= 16'h0000;
      DEV_DATA_OE_O        <= 2'h0;
    end else begin
      DEV_ADDR_O           <= {cyc_addr[12:1], lane_a0};
      HIGH_BYTE_ENABLE_N_O <= lane_hbe_n;
      CHIP_ENABLE_N_O      <= !ce_ff;
      OUTPUT_ENABLE_N_O    <= !oe_ff;
      WRITE_ENABLE_N_O     <= !(wr_ff && state_ff == HBLCS_ST_STROBE && (lane_lo || lane_hi));
      DEV_DATA_O           <= lane_dout;
      // drive only selected lanes during writes; upper lane idle in byte mode
      DEV_DATA_OE_O        <= (wr_ff && ce_ff) ? {lane_hi, lane_lo} : 2'h0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      rdata_ff <= 16'h0000;
    // sample on the edge that raises the read strobe: the strobe pin lags
    // the state by one flop, so the last strobe state is a cycle short of access
    end else if (state_ff == HBLCS_ST_HOLD && cnt_ff == 4'(`HBLCS_THIZ_CYC - 1)
                 && !wr_ff && !sel_pend_ff) begin
      rdata_ff <= lane_rdata;
    end
  end

  // done is sticky; a new start clears it, refusal set wins over clear
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      done_ff    <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      if (state_ff == HBLCS_ST_RECOV && cnt_ff == 4'h0 && !sel_pend_ff) begin
        done_ff <= 1'b1;
      end else if (start) begin
        done_ff <= 1'b0;
      end
      if (REG_WR_I && reg_hit(REG_ADDR_I, `HBLCS_REG_CMD) && (busy || init_ff)) begin
        refused_ff <= 1'b1;
      end else if (REG_RD_I && reg_hit(REG_ADDR_I, `HBLCS_REG_STATUS)) begin
        refused_ff <= 1'b0;
      end
    end
  end

  assign WIDTH_SELECT_O = ctrl_ff[`HBLCS_CTRL_WIDE];

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 32'h00000000;
    end else if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        `HBLCS_REG_CTRL:   REG_RDATA_O <= {24'h000000, ctrl_ff};
        `HBLCS_REG_ADDR:   REG_RDATA_O <= {19'h00000, addr_ff};
        `HBLCS_REG_WDATA:  REG_RDATA_O <= {16'h0000, wdata_ff};
        `HBLCS_REG_RDATA:  REG_RDATA_O <= {16'h0000, rdata_ff};
        `HBLCS_REG_STATUS: REG_RDATA_O <= {28'h0000000, refused_ff, done_ff,
                                           !init_ff, busy};
        `HBLCS_REG_DEVSEL: REG_RDATA_O <= {30'h00000000, devsel_ff};
        default:           REG_RDATA_O <= 32'h00000000;
      endcase
    end else begin
      REG_RDATA_O <= 32'h00000000;
    end
  end

endmodule : hblcs_host

// [sim/hblcs_host_monitor.sv]
/*
  checker for the host-side flash bus controller, bound to its top module.
  assumes one clock and synchronous active-low reset.
*/
`timescale 1ns/100ps
module hblcs_host_monitor (
  input wire logic        MCLK_I,
  input wire logic        RESET_N_I,
  input wire logic        REG_RD_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic [12:0] DEV_ADDR_O,
  input wire logic        CHIP_ENABLE_N_O,
  input wire logic        OUTPUT_ENABLE_N_O,
  input wire logic        WRITE_ENABLE_N_O,
  input wire logic        HIGH_BYTE_ENABLE_N_O,
  input wire logic        WIDTH_SELECT_O,
  input wire logic [1:0]  DEV_DATA_OE_O,
  input wire logic        INIT_PENDING_N_I
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence oe_start;
    $fell(OUTPUT_ENABLE_N_O);
  endsequence
  sequence oe_held;
    !OUTPUT_ENABLE_N_O [*8] ##[1:4] OUTPUT_ENABLE_N_O;
  endsequence
  property oe_pulse;
    oe_start |-> oe_held;
  endproperty
  strobe_excl_a: assert property (!(!OUTPUT_ENABLE_N_O && !WRITE_ENABLE_N_O))
    else $error("read and write strobes low together");
  ce_frames_a: assert property ((!OUTPUT_ENABLE_N_O || !WRITE_ENABLE_N_O) |->
    !CHIP_ENABLE_N_O) else $error("strobe outside chip enable");
  oe_length_a: assert property (oe_pulse) else $error("read strobe length wrong");
  init_wait_a: assert property ($fell(CHIP_ENABLE_N_O) |-> $past(INIT_PENDING_N_I, 2))
    else $error("cycle started during init pending");
  byte_lane_a: assert property (!WIDTH_SELECT_O |-> !DEV_DATA_OE_O[1])
    else $error("upper lane driven in byte mode");
  hi_lane_a: assert property (WIDTH_SELECT_O && DEV_DATA_OE_O[1] |->
    !HIGH_BYTE_ENABLE_N_O) else $error("upper lane driven without enable");
  lo_lane_a: assert property (WIDTH_SELECT_O && DEV_DATA_OE_O[0] |-> !DEV_ADDR_O[0])
    else $error("low lane driven with a0 high");
  no_xfer_a: assert property (WIDTH_SELECT_O && HIGH_BYTE_ENABLE_N_O && DEV_ADDR_O[0]
    |-> WRITE_ENABLE_N_O && DEV_DATA_OE_O == 2'h0) else $error("transfer on no-op");
  rd_contend_a: assert property (!OUTPUT_ENABLE_N_O |-> DEV_DATA_OE_O == 2'h0)
    else $error("host drives data during read");
  rdata_slot_a: assert property (REG_RDATA_O != 32'h0 |-> $past(REG_RD_I))
    else $error("read data outside its slot");
endmodule : hblcs_host_monitor

bind hblcs_host hblcs_host_monitor i_mon (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .DEV_ADDR_O(DEV_ADDR_O),
  .CHIP_ENABLE_N_O(CHIP_ENABLE_N_O), .OUTPUT_ENABLE_N_O(OUTPUT_ENABLE_N_O),
  .WRITE_ENABLE_N_O(WRITE_ENABLE_N_O), .HIGH_BYTE_ENABLE_N_O(HIGH_BYTE_ENABLE_N_O),
  .WIDTH_SELECT_O(WIDTH_SELECT_O), .DEV_DATA_OE_O(DEV_DATA_OE_O),
  .INIT_PENDING_N_I(INIT_PENDING_N_I));

// [sim/hblcs_dev_model.sv]
/*
  behavioural flash device on the strobe bus: byte memory, device select,
  init pending after reset. assumes the bench merges its lanes with the host's.
*/
`timescale 1ns/100ps
`include "hblcs_defs.svh"
module hblcs_dev_model #(
  parameter logic [1:0] POS     = 2'h0,
  parameter int         ACC_NS  = 103,
  parameter int         INIT_NS = 600
) (
  input  wire logic        rst_n_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        hbe_n_i,
  input  wire logic        wide_i,
  input  wire logic [12:0] addr_i,
  input  wire logic [15:0] d_i,
  output logic      [15:0] d_o,
  output logic             init_n_o
);
  logic [7:0]  mem [0:8191];
  logic [1:0]  sel;
  logic [15:0] last;
  logic [12:0] lo_a, hi_a;
  logic        lo_on, hi_on, rd_req, rd_late, rd_on;
  assign lo_a = wide_i ? {addr_i[12:1], 1'b0} : addr_i;
  assign hi_a = {addr_i[12:1], 1'b1};
  assign lo_on = wide_i ? !addr_i[0] : 1'b1;
  assign hi_on = wide_i & !hbe_n_i;
  assign rd_req = !ce_n_i && !oe_n_i && sel == POS && init_n_o;
  assign #(ACC_NS) rd_late = rd_req;
  assign rd_on = rd_req && rd_late;
  initial init_n_o = 1'b0;
  initial sel = 2'h0;
  always @(negedge rst_n_i) begin
    init_n_o = 1'b0;
    sel = 2'h0;
  end
  // low only across the post-reset load, never for array work
  always @(posedge rst_n_i) begin
    #(INIT_NS);
    init_n_o = 1'b1;
  end
  always @(posedge we_n_i) begin
    if (!ce_n_i && init_n_o) begin
      if (addr_i == `HBLCS_DEVSEL_ADDR) sel = d_i[1:0];
      else if (sel == POS) begin
        if (lo_on) mem[lo_a] = d_i[7:0];
        if (hi_on) mem[hi_a] = d_i[15:8];
      end
    end
  end
  always @(rd_on, lo_a, hi_a) if (rd_on) last = {mem[hi_a], mem[lo_a]};
  // undriven lanes show the inverse of the last read (upper lane 8'hFF in byte mode) so a stale value never passes
  always_comb begin
    d_o[7:0] = (rd_on && lo_on) ? mem[lo_a] : ~last[7:0];
    d_o[15:8] = (rd_on && hi_on) ? mem[hi_a] : (wide_i ? ~last[15:8] : 8'hFF);
  end
endmodule : hblcs_dev_model

// [sim/hblcs_host_tb.sv]
/*
  self-checking bench: register-port driver, read-result queue, device model.
  assumes the design files and the defs header are compiled first.
*/
`timescale 1ns/100ps
`include "hblcs_defs.svh"
module hblcs_host_tb;
  import hblcs_pkg::*;
  logic        clk, rst_n, rwr, rrd, rd_d, init_n;
  logic [3:0]  ra;
  logic [31:0] rwd, rdata, v;
  logic [12:0] dadr, a;
  logic        ce_n, oe_n, we_n, hbe_n, wide;
  logic [15:0] ddo, dev_d, bus, w;
  logic [1:0]  doe;
  logic [7:0]  b, c, d;
  logic [63:0] exp_q [$];
  int          err_total, n_compared, cyc, k, n;
  assign bus = {doe[1] ? ddo[15:8] : dev_d[15:8], doe[0] ? ddo[7:0] : dev_d[7:0]};
  hblcs_host i_dut (.MCLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(ra), .REG_WDATA_I(rwd),
    .REG_WR_I(rwr), .REG_RD_I(rrd), .REG_RDATA_O(rdata), .DEV_ADDR_O(dadr),
    .CHIP_ENABLE_N_O(ce_n), .OUTPUT_ENABLE_N_O(oe_n), .WRITE_ENABLE_N_O(we_n),
    .HIGH_BYTE_ENABLE_N_O(hbe_n), .WIDTH_SELECT_O(wide), .DEV_DATA_I(bus),
    .DEV_DATA_O(ddo), .DEV_DATA_OE_O(doe), .INIT_PENDING_N_I(init_n));
  hblcs_dev_model i_dev (.rst_n_i(rst_n), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .hbe_n_i(hbe_n), .wide_i(wide), .addr_i(dadr), .d_i(bus), .d_o(dev_d), .init_n_o(init_n));
  always #5 clk = ~clk;
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic check_rd(input logic [63:0] e);
    if (e[63:32] != 32'h0) begin
      n_compared++;
      if ((rdata & e[63:32]) !== e[31:0]) begin
        err_total++;
        $display("unexpected rdata exp %h seen %h", e[31:0], rdata & e[63:32]);
      end
    end
  endtask : check_rd
  always @(posedge clk) begin
    rd_d <= rrd;
    cyc <= cyc + 1;
    if (rd_d) check_rd(exp_q.pop_front());
    if (cyc == 9000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
    ra <= ad;
    rwd <= dt;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] ad, input logic [31:0] m, e, output logic [31:0] rv);
    exp_q.push_back({m, e});
    ra <= ad;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1 rv = rdata;
    @(posedge clk);
  endtask : rd
  task automatic xfer(input logic [2:0] ctl, input logic [12:0] ad, input logic [15:0] dt,
                      input logic [1:0] cmd);
    logic [31:0] st;
    int i;
    wr(`HBLCS_REG_CTRL, {29'h0, ctl});
    wr(`HBLCS_REG_ADDR, {19'h0, ad});
    wr(`HBLCS_REG_WDATA, {16'h0, dt});
    wr(`HBLCS_REG_CMD, {30'h0, cmd});
    for (i = 0; i < 60; i++) begin
      rd(`HBLCS_REG_STATUS, 32'h0, 32'h0, st);
      if (st[0] === 1'b0) break;
    end
    rd(`HBLCS_REG_STATUS, 32'hF, 32'h6, st);
  endtask : xfer
  task automatic chk(input logic [2:0] ctl, input logic [12:0] ad, input logic [31:0] m, e);
    xfer(ctl, ad, 16'h0, `HBLCS_CMD_READ);
    rd(`HBLCS_REG_RDATA, m, e, v);
  endtask : chk
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ra = 4'h0;
    rwd = 32'h0;
    rwr = 1'b0;
    rrd = 1'b0;
    cyc = 0;
    void'($urandom(6));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wr(`HBLCS_REG_CMD, {30'h0, `HBLCS_CMD_READ});
    rd(`HBLCS_REG_STATUS, 32'hF, 32'h8, v);
    for (n = 0; n < 200 && init_n !== 1'b1; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    rd(`HBLCS_REG_STATUS, 32'hF, 32'h2, v);
    for (k = 0; k < 4; k++) begin
      a = 13'($urandom_range(0, 2047)) << 1;
      w = 16'($urandom);
      b = 8'($urandom);
      c = 8'($urandom);
      d = 8'($urandom);
      xfer(3'b001, a, w, `HBLCS_CMD_WRITE);
      chk(3'b001, a, 32'hFFFF, {16'h0, w});
      xfer(3'b011, a, {~b, b}, `HBLCS_CMD_WRITE);
      xfer(3'b101, a, {c, c}, `HBLCS_CMD_WRITE);
      xfer(3'b111, a, 16'($urandom), `HBLCS_CMD_WRITE);
      chk(3'b001, a, 32'hFFFF, {16'h0, c, b});
      chk(3'b011, a, 32'hFF, {24'h0, b});
      chk(3'b101, a, 32'hFF, {24'h0, c});
      chk(3'b000, a | 13'h1, 32'hFF, {24'h0, c});
      xfer(3'b000, a, {~d, d}, `HBLCS_CMD_WRITE);
      chk(3'b001, a, 32'hFFFF, {16'h0, c, d});
      wr(`HBLCS_REG_DEVSEL, 32'h1);
      xfer(3'b001, a, ~w, `HBLCS_CMD_WRITE);
      wr(`HBLCS_REG_DEVSEL, 32'h0);
      chk(3'b001, a, 32'hFFFF, {16'h0, c, d});
    end
    report_and_stop();
  end
endmodule : hblcs_host_tb
